/* testbench/cascaded_filter_stream_ports_tb_top.sv */
`timescale 1ns/10ps
module cascaded_filter_stream_ports_tb_top
  import cfsp_pkg::*;
;
  logic clk, rst, ce, clr_n, psel, pen, pwr, pready, perr, cv, cr, iv, ir, il;
  logic ov, ordy, ol, osync, em, eu, eh, seen_h, seen_s, err, slast;
  logic [7:0] pa;
  logic [31:0] pwd, prd, od, rd, sdata;
  logic [15:0] cd, id, scnt;
  logic [3:0] oidx, stall;
  logic [15:0] cin [3] = '{16'h0002, 16'h3000, 16'h0005};
  logic [31:0] cexp [3] = '{{18'h0, CFSP_RATE_MIN}, {18'h0, CFSP_RATE_MAX}, 32'h5};
  int miscompares, num_checks, cyc;
  cfsp_top dut_u (.SYS_CLK(clk), .RST(rst), .CLK_EN(ce), .SCLR_N(clr_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .CFG_VALID(cv), .CFG_READY(cr), .CFG_DATA(cd), .IN_VALID(iv),
    .IN_READY(ir), .IN_DATA(id), .IN_LAST(il), .OUT_VALID(ov), .OUT_READY(ordy),
    .OUT_DATA(od), .OUT_LAST(ol), .OUT_CHANNEL_INDEX(oidx), .OUT_CHANNEL_SYNC(osync),
    .EVENT_LAST_MISSING(em), .EVENT_LAST_UNEXPECTED(eu), .EVENT_HALTED(eh));
  cfsp_sink snk_u (.clk(clk), .rst(rst), .out_valid(ov), .out_data(od), .out_last(ol),
    .stall(stall), .out_ready(ordy), .got_data(sdata), .got_last(slast), .got_cnt(scnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ********************
  // tasks
  // ********************
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cfg(input logic [15:0] d);
    @(posedge clk);
    cv <= 1'b1;
    cd <= d;
    do @(posedge clk); while (cr !== 1'b1);
    cv <= 1'b0;
    cd <= ~d;
  endtask
  task automatic send(input logic [15:0] d, input logic l);
    @(posedge clk);
    iv <= 1'b1;
    id <= d;
    il <= l;
    do @(posedge clk); while (ir !== 1'b1);
    iv <= 1'b0;
    id <= ~d;
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // long stalls would hang here, so a cycle ceiling ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (eh === 1'b1) seen_h <= 1'b1;
    if (ov === 1'b1 && osync === 1'b1) seen_s <= 1'b1;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  // ********************
  // sequence
  // ********************
  initial begin
    {rst, ce, clr_n} = 3'h7;
    {psel, pen, pwr, cv, iv, il, seen_h, seen_s} = 8'h00;
    {pa, pwd, cd, id, stall} = '0;
    {miscompares, num_checks, cyc} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, CFSP_OFF_CTRL, 32'h0);
    check("ctrl", rd, CFSP_CTRL_RESET);
    apb(1'b0, CFSP_OFF_RATE, 32'h0);
    check("rate", rd, {18'h0, CFSP_RATE_RESET});
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      cfg(cin[i]);
      apb(1'b0, CFSP_OFF_RATE, 32'h0);
      check("rate", rd, cexp[i]);
    end
    cfg(16'h0004);
    $display("test config done");
    for (int i = 1; i < 5; i++) send(i[15:0], 1'b0);
    repeat (3) @(posedge clk);
    check("sum", sdata, 32'd10);
    ce <= 1'b0;
    iv <= 1'b1;
    id <= 16'h0007;
    repeat (3) @(posedge clk);
    iv <= 1'b0;
    ce <= 1'b1;
    for (int i = 0; i < 4; i++) send(16'h0005, 1'b0);
    repeat (3) @(posedge clk);
    check("frozen sum", sdata, 32'd20);
    apb(1'b0, CFSP_OFF_OUTCNT, 32'h0);
    check("outcnt", rd, 32'h2);
    apb(1'b0, CFSP_OFF_EVCNT, 32'h0);
    check("no events", rd, 32'h0);
    $display("test single channel done");
    apb(1'b1, CFSP_OFF_CTRL, 32'h13);
    apb(1'b1, CFSP_OFF_EVCNT, 32'h0);
    stall <= 4'h3;
    for (int i = 0; i < 8; i++) send(i[15:0] + 16'h1, (i == 0) || (i[0] && i != 3));
    repeat (8) @(posedge clk);
    check("ch1 sum", sdata, 32'd20);
    check("out index", {28'h0, oidx}, 32'h1);
    check("sync seen", {31'h0, seen_s}, 32'h1);
    check("out last", {31'h0, slast}, 32'h1);
    check("halted", {31'h0, seen_h}, 32'h1);
    check("sink count", {16'h0, scnt}, 32'h4);
    apb(1'b0, CFSP_OFF_STATUS, 32'h0);
    check("status", rd, 32'h0000_0012);
    apb(1'b0, CFSP_OFF_EVCNT, 32'h0);
    check("missing", {16'h0, rd[15:0]}, 32'h1);
    check("unexpected", {16'h0, rd[31:16]}, 32'h1);
    $display("test multichannel done");
    cfg(16'h0009);
    clr_n <= 1'b0;
    repeat (2) @(posedge clk);
    clr_n <= 1'b1;
    apb(1'b0, CFSP_OFF_RATE, 32'h0);
    check("rate", rd, {18'h0, CFSP_RATE_RESET});
    apb(1'b0, CFSP_OFF_CTRL, 32'h0);
    check("ctrl", rd, 32'h13);
    $display("test clear done");
    results();
  end
endmodule

/* testbench/cfsp_sink.sv */
`timescale 1ns/10ps
module cfsp_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic out_last,
  input wire logic [3:0] stall,
  output logic out_ready,
  output logic [31:0] got_data,
  output logic got_last,
  output logic [15:0] got_cnt
);
  logic [3:0] wait_cnt;
  // ready held back for stall cycles of each sample, like a slow consumer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 4'h0;
      out_ready <= 1'b0;
    end else if (out_valid && !out_ready) begin
      wait_cnt <= wait_cnt + 4'h1;
      out_ready <= (wait_cnt + 4'h1 >= stall);
    end else begin
      wait_cnt <= 4'h0;
      out_ready <= (stall == 4'h0);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_data <= 32'h0;
      got_last <= 1'b0;
      got_cnt <= 16'h0;
    end else if (out_valid && out_ready) begin
      got_data <= out_data;
      got_last <= out_last;
      got_cnt <= got_cnt + 16'h1;
    end
  end
endmodule

/* testbench/cfsp_top_asserts.sv */
`timescale 1ns/10ps
module cfsp_top_asserts
  import cfsp_pkg::*;
#(
  parameter int OUT_W = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic SCLR_N,
  input wire logic CFG_READY,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic IN_LAST,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [OUT_W-1:0] OUT_DATA,
  input wire logic OUT_LAST,
  input wire logic [CFSP_CH_W-1:0] OUT_CHANNEL_INDEX,
  input wire logic OUT_CHANNEL_SYNC,
  input wire logic EVENT_LAST_MISSING,
  input wire logic EVENT_LAST_UNEXPECTED,
  input wire logic EVENT_HALTED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ********************
  // properties
  // ********************
  property p_freeze;
    !CLK_EN && SCLR_N |=> $stable(OUT_VALID) && $stable(OUT_DATA) && $stable(IN_READY)
      && $stable(CFG_READY) && $stable(EVENT_HALTED);
  endproperty
  property p_clear;
    !SCLR_N |=> !CFG_READY && !IN_READY && !OUT_VALID && !EVENT_HALTED && !EVENT_LAST_MISSING;
  endproperty
  property p_miss;
    EVENT_LAST_MISSING && $past(CLK_EN) |-> $past(IN_VALID && IN_READY && !IN_LAST);
  endproperty
  property p_unexp;
    EVENT_LAST_UNEXPECTED && $past(CLK_EN) |-> $past(IN_VALID && IN_READY && IN_LAST);
  endproperty
  property p_halt;
    EVENT_HALTED && $past(CLK_EN) |-> $past(OUT_VALID && !OUT_READY && IN_VALID);
  endproperty
  property p_stop;
    OUT_VALID |-> !IN_READY;
  endproperty
  // a clear also drops valid, so only a real take counts here
  property p_resume;
    $fell(OUT_VALID) && $past(CLK_EN && SCLR_N) |-> IN_READY;
  endproperty
  property p_sync;
    OUT_VALID && OUT_CHANNEL_SYNC |-> OUT_CHANNEL_INDEX == 0;
  endproperty
  property p_hold;
    OUT_VALID && $past(OUT_VALID && !OUT_READY) |-> $stable(OUT_DATA) && $stable(OUT_LAST)
      && $stable(OUT_CHANNEL_INDEX);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");
  a_clear: assert property (p_clear) else $error("clear did not empty outputs");
  a_miss: assert property (p_miss) else $error("missing event without cause");
  a_unexp: assert property (p_unexp) else $error("unexpected event without cause");
  a_halt: assert property (p_halt) else $error("halted without full output");
  a_stop: assert property (p_stop) else $error("input ready while output full");
  a_resume: assert property (p_resume) else $error("input not ready after take");
  a_sync: assert property (p_sync) else $error("sync off channel zero");
  a_hold: assert property (p_hold) else $error("output changed before take");
  c_halt: cover property (EVENT_HALTED);
  c_sync: cover property (OUT_VALID && OUT_CHANNEL_SYNC);
  c_miss: cover property (EVENT_LAST_MISSING);
  c_unexp: cover property (EVENT_LAST_UNEXPECTED);
endmodule

bind cfsp_top cfsp_top_asserts #(.OUT_W(OUT_W)) chk_u (.SYS_CLK, .RST, .CLK_EN, .SCLR_N,
  .CFG_READY, .IN_VALID, .IN_READY, .IN_LAST, .OUT_VALID, .OUT_READY, .OUT_DATA, .OUT_LAST,
  .OUT_CHANNEL_INDEX, .OUT_CHANNEL_SYNC, .EVENT_LAST_MISSING, .EVENT_LAST_UNEXPECTED,
  .EVENT_HALTED);

/* verilog/cfsp_cfg_chan.sv */
`timescale 1ns/10ps
module cfsp_cfg_chan
  import cfsp_pkg::*;
#(
  parameter int CFG_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr_n,
  input wire logic cfg_valid,
  input wire logic [CFG_W-1:0] cfg_data,
  output logic cfg_ready,
  output logic cfg_take,
  output logic [CFSP_RATE_W-1:0] rate
);
  logic [CFSP_RATE_W-1:0] req;

  assign req = cfg_data[CFSP_RATE_W-1:0];
  assign cfg_take = ce && clr_n && cfg_valid && cfg_ready;

  // ready drops only on reset or while clear is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ready <= 1'b0;
    end else if (!clr_n) begin
      cfg_ready <= 1'b0;
    end else if (ce) begin
      cfg_ready <= 1'b1;
    end
  end

  // out-of-range words are clamped, not rejected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate <= CFSP_RATE_RESET;
    end else if (!clr_n) begin
      rate <= CFSP_RATE_RESET;
    end else if (cfg_take) begin
      if (req < CFSP_RATE_MIN) begin
        rate <= CFSP_RATE_MIN;
      end else if (req > CFSP_RATE_MAX) begin
        rate <= CFSP_RATE_MAX;
      end else begin
        rate <= req;
      end
    end
  end
endmodule

/* verilog/cfsp_event_gen.sv */
`timescale 1ns/10ps
module cfsp_event_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr_n,
  input wire logic mc_en,
  input wire logic in_take,
  input wire logic final_ch,
  input wire logic in_last,
  input wire logic halt_need,
  output logic ev_missing,
  output logic ev_unexpected,
  output logic ev_halted
);
  // ********************
  // event pulses
  // ********************
  // recomputed every enabled cycle, so missing and unexpected last one enabled cycle per take; halted stays up while halt_need holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_missing <= 1'b0;
      ev_unexpected <= 1'b0;
      ev_halted <= 1'b0;
    end else if (!clr_n) begin
      ev_missing <= 1'b0;
      ev_unexpected <= 1'b0;
      ev_halted <= 1'b0;
    end else if (ce) begin
      ev_missing <= mc_en && in_take && final_ch && !in_last;
      ev_unexpected <= mc_en && in_take && !final_ch && in_last;
      ev_halted <= halt_need;
    end
  end
endmodule

/* verilog/cfsp_pkg.sv */
package cfsp_pkg;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] CFSP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CFSP_OFF_STATUS = 8'h04;
  localparam logic [7:0] CFSP_OFF_RATE = 8'h08;
  localparam logic [7:0] CFSP_OFF_EVCNT = 8'h0c;
  localparam logic [7:0] CFSP_OFF_OUTCNT = 8'h10;
  localparam logic [31:0] CFSP_CTRL_RESET = 32'h0000_0000;

  // ********************
  // fields
  // ********************
  localparam int CFSP_CTRL_MC_BIT = 0;
  localparam int CFSP_CTRL_BP_BIT = 1;
  localparam int CFSP_CTRL_LCH_LSB = 4;
  localparam int CFSP_ST_OVALID_BIT = 0;
  localparam int CFSP_ST_IREADY_BIT = 1;
  localparam int CFSP_ST_STATE_LSB = 4;
  localparam int CFSP_ST_CH_LSB = 8;
  localparam int CFSP_EV_MISS_LSB = 0;
  localparam int CFSP_EV_UNEXP_LSB = 16;
  localparam int CFSP_CH_W = 4;

  // ********************
  // rate limits
  // ********************
  localparam int CFSP_RATE_W = 14;
  localparam logic [13:0] CFSP_RATE_MIN = 14'h0004;
  localparam logic [13:0] CFSP_RATE_MAX = 14'h2000;
  localparam logic [13:0] CFSP_RATE_RESET = 14'h0004;

  typedef enum logic [1:0] {CFSP_IDLE, CFSP_RUN, CFSP_HALT} cfsp_state_e;

endpackage

/* verilog/cfsp_top.sv */
`timescale 1ns/10ps
module cfsp_top
  import cfsp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int OUT_W = 32,
  parameter int CFG_W = 16,
  parameter int MAX_CH = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic SCLR_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CFG_VALID,
  output logic CFG_READY,
  input wire logic [CFG_W-1:0] CFG_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [DATA_W-1:0] IN_DATA,
  input wire logic IN_LAST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [OUT_W-1:0] OUT_DATA,
  output logic OUT_LAST,
  output logic [CFSP_CH_W-1:0] OUT_CHANNEL_INDEX,
  output logic OUT_CHANNEL_SYNC,
  output logic EVENT_LAST_MISSING,
  output logic EVENT_LAST_UNEXPECTED,
  output logic EVENT_HALTED
);

  // ********************
  // declarations
  // ********************
  logic [31:0] ctrl;
  logic mc_en;
  logic bp_en;
  logic [CFSP_CH_W-1:0] last_ch;
  logic ce;
  logic clr_n;
  logic cfg_take;
  logic [CFSP_RATE_W-1:0] rate;
  logic [CFSP_CH_W-1:0] ch;
  logic [CFSP_RATE_W-1:0] ph;
  logic final_ch;
  logic frame_end;
  logic in_take;
  logic out_take;
  logic emit;
  logic halt_need;
  logic next_out_valid;
  logic [OUT_W-1:0] acc [MAX_CH];
  logic [OUT_W-1:0] sample_ext;
  logic [OUT_W-1:0] sum;
  cfsp_state_e state;
  cfsp_state_e next_state;
  logic [15:0] miss_cnt;
  logic [15:0] unexp_cnt;
  logic miss_hit;
  logic unexp_hit;
  logic [31:0] out_cnt;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic rd_err;

  assign ce = CLK_EN;
  assign clr_n = SCLR_N;
  assign mc_en = ctrl[CFSP_CTRL_MC_BIT];
  assign bp_en = ctrl[CFSP_CTRL_BP_BIT];
  assign last_ch = ctrl[CFSP_CTRL_LCH_LSB +: CFSP_CH_W];

  // ********************
  // configuration channel
  // ********************
  cfsp_cfg_chan #(
    .CFG_W(CFG_W)
  ) u_cfg (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(ce),
    .clr_n(clr_n),
    .cfg_valid(CFG_VALID),
    .cfg_data(CFG_DATA),
    .cfg_ready(CFG_READY),
    .cfg_take(cfg_take),
    .rate(rate)
  );

  // ********************
  // handshakes
  // ********************
  assign in_take = ce && clr_n && IN_VALID && IN_READY;
  // without back-pressure the sink is taken as always ready
  assign out_take = ce && clr_n && OUT_VALID && (OUT_READY || !bp_en);
  assign final_ch = mc_en ? (ch == last_ch) : 1'b1;
  assign frame_end = (ph == rate - 14'h0001);
  assign emit = in_take && frame_end;
  assign halt_need = ce && clr_n && bp_en && OUT_VALID && !OUT_READY && IN_VALID;

  always_comb begin
    next_out_valid = OUT_VALID;
    if (emit) begin
      next_out_valid = 1'b1;
    end else if (out_take) begin
      next_out_valid = 1'b0;
    end
  end

  // a full output slot closes the input; channel, phase and sums then change only on a clear or a config take
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IN_READY <= 1'b0;
    end else if (!clr_n) begin
      IN_READY <= 1'b0;
    end else if (ce) begin
      IN_READY <= !next_out_valid;
    end
  end

  // ********************
  // channel and frame tracking
  // ********************
  // channel order is kept locally; the input marker never steers it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ch <= '0;
      ph <= '0;
    end else if (!clr_n || cfg_take) begin
      ch <= '0;
      ph <= '0;
    end else if (in_take) begin
      if (final_ch) begin
        ch <= '0;
        ph <= frame_end ? '0 : ph + 14'h0001;
      end else begin
        ch <= ch + 4'h1;
      end
    end
  end

  // ********************
  // per-channel accumulators
  // ********************
  assign sample_ext = {{(OUT_W - DATA_W){IN_DATA[DATA_W-1]}}, IN_DATA};
  assign sum = acc[ch] + sample_ext;

  // boxcar sum over one rate period, dumped at frame end
  for (genvar g = 0; g < MAX_CH; g++) begin : g_acc
    always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
        acc[g] <= '0;
      end else if (!clr_n || cfg_take) begin
        acc[g] <= '0;
      end else if (in_take && ch == CFSP_CH_W'(g)) begin
        acc[g] <= frame_end ? '0 : sum;
      end
    end
  end

  // ********************
  // output channel
  // ********************
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      OUT_VALID <= 1'b0;
    end else if (!clr_n) begin
      OUT_VALID <= 1'b0;
    end else if (ce) begin
      OUT_VALID <= next_out_valid;
    end
  end

  // loaded only on emit, which cannot meet a waiting sample
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      OUT_DATA <= '0;
      OUT_LAST <= 1'b0;
      OUT_CHANNEL_INDEX <= '0;
      OUT_CHANNEL_SYNC <= 1'b0;
    end else if (!clr_n) begin
      OUT_DATA <= '0;
      OUT_LAST <= 1'b0;
      OUT_CHANNEL_INDEX <= '0;
      OUT_CHANNEL_SYNC <= 1'b0;
    end else if (emit) begin
      OUT_DATA <= sum;
      OUT_LAST <= mc_en && final_ch;
      OUT_CHANNEL_INDEX <= mc_en ? ch : '0;
      OUT_CHANNEL_SYNC <= mc_en && (ch == '0);
    end
  end

  // ********************
  // run state
  // ********************
  always_comb begin
    next_state = state;
    case (state)
      CFSP_IDLE: begin
        next_state = CFSP_RUN;
      end
      CFSP_RUN: begin
        if (bp_en && next_out_valid && !OUT_READY) begin
          next_state = CFSP_HALT;
        end
      end
      CFSP_HALT: begin
        if (out_take) begin
          next_state = CFSP_RUN;
        end
      end
      default: begin
        next_state = CFSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= CFSP_IDLE;
    end else if (!clr_n) begin
      state <= CFSP_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ********************
  // events
  // ********************
  cfsp_event_gen u_ev (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(ce),
    .clr_n(clr_n),
    .mc_en(mc_en),
    .in_take(in_take),
    .final_ch(final_ch),
    .in_last(IN_LAST),
    .halt_need(halt_need),
    .ev_missing(EVENT_LAST_MISSING),
    .ev_unexpected(EVENT_LAST_UNEXPECTED),
    .ev_halted(EVENT_HALTED)
  );

  // ********************
  // apb slave
  // ********************
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (PADDR == CFSP_OFF_CTRL) begin
      rd_mux = ctrl;
    end else if (PADDR == CFSP_OFF_STATUS) begin
      rd_mux[CFSP_ST_OVALID_BIT] = OUT_VALID;
      rd_mux[CFSP_ST_IREADY_BIT] = IN_READY;
      rd_mux[CFSP_ST_STATE_LSB +: 2] = state;
      rd_mux[CFSP_ST_CH_LSB +: CFSP_CH_W] = ch;
    end else if (PADDR == CFSP_OFF_RATE) begin
      rd_mux[CFSP_RATE_W-1:0] = rate;
    end else if (PADDR == CFSP_OFF_EVCNT) begin
      rd_mux[CFSP_EV_MISS_LSB +: 16] = miss_cnt;
      rd_mux[CFSP_EV_UNEXP_LSB +: 16] = unexp_cnt;
    end else if (PADDR == CFSP_OFF_OUTCNT) begin
      rd_mux = out_cnt;
    end else begin
      rd_err = 1'b1;
    end
  end

  // answer is ready in the first access cycle: zero wait states
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_setup;
    end
  end

  // read data stands only in the access cycle, zero otherwise
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= (apb_setup && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= apb_setup && rd_err;
    end
  end

  // bus registers stay live when the filter clock enable is low
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= CFSP_CTRL_RESET;
    end else if (apb_wr && PADDR == CFSP_OFF_CTRL) begin
      ctrl <= PWDATA & 32'h0000_00f3;
    end
  end

  // ********************
  // event counters
  // ********************
  // events hold while the enable is low, so only enabled cycles count
  assign miss_hit = ce && EVENT_LAST_MISSING;
  assign unexp_hit = ce && EVENT_LAST_UNEXPECTED;

  // write clears; a same-cycle event still counts
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      miss_cnt <= '0;
      unexp_cnt <= '0;
    end else if (apb_wr && PADDR == CFSP_OFF_EVCNT) begin
      miss_cnt <= {15'h0000, miss_hit};
      unexp_cnt <= {15'h0000, unexp_hit};
    end else begin
      miss_cnt <= miss_cnt + {15'h0000, miss_hit};
      unexp_cnt <= unexp_cnt + {15'h0000, unexp_hit};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      out_cnt <= '0;
    end else if (apb_wr && PADDR == CFSP_OFF_OUTCNT) begin
      out_cnt <= {31'h0000_0000, out_take};
    end else if (out_take) begin
      out_cnt <= out_cnt + 32'h0000_0001;
    end
  end

endmodule
